//--- core/rcl_pkg.sv
// Package for the reset cause logger: register map, flag layout, timing and carriers
package rcl_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] ADDR_CAUSE  = 8'h00;
  localparam logic [7:0] ADDR_SEG_LO = 8'h04;
  localparam logic [7:0] ADDR_SEG_HI = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h0c;

  // Register indices after decode
  localparam logic [2:0] IDX_CAUSE  = 3'h0;
  localparam logic [2:0] IDX_SEG_LO = 3'h1;
  localparam logic [2:0] IDX_SEG_HI = 3'h2;
  localparam logic [2:0] IDX_CTRL   = 3'h3;
  localparam logic [2:0] IDX_NONE   = 3'h7;

  // Reset-cause register bit positions
  localparam int BIT_TRAP_CONFLICT = 15;
  localparam int BIT_ILLEGAL_COND  = 14;
  localparam int BIT_CFG_MISMATCH  = 9;
  localparam int BIT_PIN_RESET     = 7;
  localparam int BIT_SW_RESET      = 6;
  localparam int BIT_WDT_TIMEOUT   = 4;
  localparam int BIT_SLEEP         = 3;
  localparam int BIT_IDLE          = 2;
  localparam int BIT_BROWNOUT      = 1;
  localparam int BIT_POWER_ON      = 0;

  localparam logic [15:0] CAUSE_MASK     = 16'hc2df;
  localparam logic [15:0] CAUSE_BOR_CLR  = 16'hc24c;
  localparam logic [15:0] CAUSE_RESET    = 16'h0003;

  // Control register fields and reset values
  localparam int BIT_CTRL_MM_EN  = 0;
  localparam int BIT_CTRL_SEC_EN = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h1;
  localparam logic [23:0] SEG_LO_RESET = 24'h000000;
  localparam logic [23:0] SEG_HI_RESET = 24'h000000;

  // Hard trap priority levels
  localparam logic [3:0] LVL_ADDR_ERR = 4'hd;
  localparam logic [3:0] LVL_OSC_FAIL = 4'he;
  localparam logic [3:0] LVL_HARD_TOP = 4'hf;

  localparam logic [7:0] OPC_ILLEGAL = 8'h3f;
  localparam logic [3:0] WREG_STACK  = 4'hf;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // System reset hold time after the request drops
  localparam int CLK_PERIOD_NS = 100;
  localparam int RST_HOLD_NS   = 200;
  localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } rcl_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rcl_axi_rsp_t;

  typedef struct packed {
    logic [15:0] cause;
    logic [23:0] seg_lo;
    logic [23:0] seg_hi;
    logic [1:0]  ctrl;
    logic        aw_have;
    logic [7:0]  awaddr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  hold_cnt;
    logic        wake;
  } rcl_state_t;

  typedef struct packed {
    logic [15:0] valid;
  } rcl_wreg_state_t;

endpackage

//--- core/rcl_top.sv
// Reset cause logger: reset requests, sticky cause flags and AXI4-Lite registers
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
module rcl_top #(
  parameter int  PPS_W = 16,
  parameter int  PA_W  = 24,
  parameter bit  MM_EN = 1'b1
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_b,
  input  wire rcl_pkg::rcl_axi_req_t i_axi,
  output rcl_pkg::rcl_axi_rsp_t      o_axi,
  input  wire logic                  i_por,
  input  wire logic                  i_bor,
  input  wire logic                  i_master_clear_pin_rst,
  input  wire logic                  i_sw_reset,
  input  wire logic                  i_wdt_timeout,
  input  wire logic                  i_cpu_sleep,
  input  wire logic                  i_cpu_idle,
  input  wire logic                  i_psave_sleep,
  input  wire logic                  i_psave_idle,
  input  wire logic                  i_wdog_clear,
  input  wire logic [2:0]            i_hard_trap,
  input  wire logic                  i_trap_busy,
  input  wire logic [3:0]            i_trap_busy_lvl,
  input  wire logic [PPS_W-1:0]      i_pps_ctrl,
  input  wire logic [PPS_W-1:0]      i_pps_shadow,
  input  wire logic                  i_pps_update,
  input  wire logic                  i_op_exec,
  input  wire logic [23:0]           i_op_word,
  input  wire logic                  i_wreg_wr,
  input  wire logic [3:0]            i_wreg_wr_idx,
  input  wire logic                  i_ptr_use,
  input  wire logic [3:0]            i_ptr_idx,
  input  wire logic                  i_prog_flow,
  input  wire logic                  i_vec_flow,
  input  wire logic [PA_W-1:0]       i_flow_target,
  output logic                       o_sys_rst,
  output logic                       o_wake,
  output logic [15:0]                o_cause
);

  rcl_pkg::rcl_state_t st_r;
  rcl_pkg::rcl_state_t st_nxt;

  logic wdt_rst;
  logic wdt_wake;
  logic trap_conflict;
  logic cfg_mismatch;
  logic illegal_op;
  logic uninit_ptr;
  logic sec_viol;
  logic illegal_cond;
  logic rst_req;
  logic wr_commit;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;

  // Register index decode, shared by the read and write paths
  function automatic logic [2:0] reg_decode(input logic [7:0] addr);
    logic [2:0] idx;
    if (addr == rcl_pkg::ADDR_CAUSE)
      idx = rcl_pkg::IDX_CAUSE;
    else if (addr == rcl_pkg::ADDR_SEG_LO)
      idx = rcl_pkg::IDX_SEG_LO;
    else if (addr == rcl_pkg::ADDR_SEG_HI)
      idx = rcl_pkg::IDX_SEG_HI;
    else if (addr == rcl_pkg::ADDR_CTRL)
      idx = rcl_pkg::IDX_CTRL;
    else
      idx = rcl_pkg::IDX_NONE;
    return idx;
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = new_v[8*b +: 8];
    end
    return res;
  endfunction

  // Hard trap requests by bit: level 13, 14, 15
  function automatic logic trap_lower(input logic [2:0] req, input logic [3:0] busy_lvl);
    logic hit;
    hit = 1'b0;
    if (req[0] && busy_lvl > rcl_pkg::LVL_ADDR_ERR)
      hit = 1'b1;
    if (req[1] && busy_lvl > rcl_pkg::LVL_OSC_FAIL)
      hit = 1'b1;
    if (req[2] && busy_lvl > rcl_pkg::LVL_HARD_TOP)
      hit = 1'b1;
    return hit;
  endfunction

  rcl_wreg_track u_wreg (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_clear    (o_sys_rst || i_por || i_bor),
    .i_wr       (i_wreg_wr),
    .i_wr_idx   (i_wreg_wr_idx),
    .i_ptr_use  (i_ptr_use),
    .i_ptr_idx  (i_ptr_idx),
    .o_uninit   (uninit_ptr)
  );

  // Event detection is combinational so the reset line follows at once
  assign wdt_rst       = i_wdt_timeout && !i_cpu_sleep && !i_cpu_idle;
  assign wdt_wake      = i_wdt_timeout && (i_cpu_sleep || i_cpu_idle);
  assign trap_conflict = i_trap_busy && trap_lower(i_hard_trap, i_trap_busy_lvl);
  // A sanctioned update moves both copies; only a difference outside it counts
  assign cfg_mismatch  = MM_EN && st_r.ctrl[rcl_pkg::BIT_CTRL_MM_EN] && !i_pps_update
                         && (i_pps_ctrl != i_pps_shadow);
  assign illegal_op    = i_op_exec && (i_op_word[23:16] == rcl_pkg::OPC_ILLEGAL);
  assign sec_viol      = st_r.ctrl[rcl_pkg::BIT_CTRL_SEC_EN] && (i_prog_flow || i_vec_flow)
                         && (i_flow_target >= st_r.seg_lo[PA_W-1:0])
                         && (i_flow_target <= st_r.seg_hi[PA_W-1:0]);
  assign illegal_cond  = illegal_op || uninit_ptr || sec_viol;
  // Register writes are absent here on purpose: a flag set by software never resets
  assign rst_req       = wdt_rst || trap_conflict || cfg_mismatch || illegal_cond
                         || i_master_clear_pin_rst || i_sw_reset;

  assign wr_idx    = reg_decode(st_r.awaddr);
  assign rd_idx    = reg_decode(i_axi.araddr);
  assign wr_commit = st_r.aw_have && st_r.w_have && !st_r.bvalid;

  always_comb
  begin
    logic [31:0] merged;
    merged = 32'h0000_0000;
    st_nxt = st_r;
    st_nxt.wake = wdt_wake;

    // Write address and data are taken independently
    if (i_axi.awvalid && !st_r.aw_have && !st_r.bvalid)
    begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr  = i_axi.awaddr;
    end
    if (i_axi.wvalid && !st_r.w_have && !st_r.bvalid)
    begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata  = i_axi.wdata;
      st_nxt.wstrb  = i_axi.wstrb;
    end
    if (st_r.bvalid && i_axi.bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_commit)
    begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = rcl_pkg::RESP_OKAY;
      if (wr_idx == rcl_pkg::IDX_CAUSE)
      begin
        merged = strb_merge({16'h0000, st_r.cause}, st_r.wdata, st_r.wstrb);
        st_nxt.cause = merged[15:0] & rcl_pkg::CAUSE_MASK;
      end
      else if (wr_idx == rcl_pkg::IDX_SEG_LO)
      begin
        merged = strb_merge({8'h00, st_r.seg_lo}, st_r.wdata, st_r.wstrb);
        st_nxt.seg_lo = merged[23:0];
      end
      else if (wr_idx == rcl_pkg::IDX_SEG_HI)
      begin
        merged = strb_merge({8'h00, st_r.seg_hi}, st_r.wdata, st_r.wstrb);
        st_nxt.seg_hi = merged[23:0];
      end
      else if (wr_idx == rcl_pkg::IDX_CTRL)
      begin
        merged = strb_merge({30'h0000_0000, st_r.ctrl}, st_r.wdata, st_r.wstrb);
        st_nxt.ctrl = merged[1:0];
      end
      else
      begin
        st_nxt.bresp = rcl_pkg::RESP_SLVERR;
      end
    end

    // Read channel: one outstanding read, data from flops
    if (st_r.rvalid && i_axi.rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (i_axi.arvalid && !st_r.rvalid)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = rcl_pkg::RESP_OKAY;
      if (rd_idx == rcl_pkg::IDX_CAUSE)
        st_nxt.rdata = {16'h0000, st_r.cause};
      else if (rd_idx == rcl_pkg::IDX_SEG_LO)
        st_nxt.rdata = {8'h00, st_r.seg_lo};
      else if (rd_idx == rcl_pkg::IDX_SEG_HI)
        st_nxt.rdata = {8'h00, st_r.seg_hi};
      else if (rd_idx == rcl_pkg::IDX_CTRL)
        st_nxt.rdata = {30'h0000_0000, st_r.ctrl};
      else
      begin
        st_nxt.rdata = 32'h0000_0000;
        st_nxt.rresp = rcl_pkg::RESP_SLVERR;
      end
    end

    // Hardware clears come after software writes, hardware sets last so they win
    if (i_por)
    begin
      st_nxt.cause = 16'h0000;
      st_nxt.cause[rcl_pkg::BIT_POWER_ON] = 1'b1;
      st_nxt.cause[rcl_pkg::BIT_BROWNOUT] = 1'b1;
    end
    else if (i_bor)
    begin
      st_nxt.cause = st_nxt.cause & ~rcl_pkg::CAUSE_BOR_CLR;
      st_nxt.cause[rcl_pkg::BIT_WDT_TIMEOUT] = 1'b0;
      st_nxt.cause[rcl_pkg::BIT_BROWNOUT] = 1'b1;
    end
    if (i_wdog_clear || i_psave_sleep || i_psave_idle)
    begin
      st_nxt.cause[rcl_pkg::BIT_WDT_TIMEOUT] = 1'b0;
    end
    if (i_psave_sleep)
      st_nxt.cause[rcl_pkg::BIT_SLEEP] = 1'b1;
    if (i_psave_idle)
      st_nxt.cause[rcl_pkg::BIT_IDLE] = 1'b1;
    if (wdt_rst)
      st_nxt.cause[rcl_pkg::BIT_WDT_TIMEOUT] = 1'b1;
    if (trap_conflict)
      st_nxt.cause[rcl_pkg::BIT_TRAP_CONFLICT] = 1'b1;
    if (cfg_mismatch)
      st_nxt.cause[rcl_pkg::BIT_CFG_MISMATCH] = 1'b1;
    if (illegal_cond)
      st_nxt.cause[rcl_pkg::BIT_ILLEGAL_COND] = 1'b1;
    if (i_master_clear_pin_rst)
      st_nxt.cause[rcl_pkg::BIT_PIN_RESET] = 1'b1;
    if (i_sw_reset)
      st_nxt.cause[rcl_pkg::BIT_SW_RESET] = 1'b1;

    // Stretch the reset so the core sees at least one full instruction cycle
    if (rst_req)
      st_nxt.hold_cnt = 4'(rcl_pkg::RST_HOLD_CYC);
    else if (st_r.hold_cnt != 4'h0)
      st_nxt.hold_cnt = st_r.hold_cnt - 4'h1;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      st_r          <= '0;
      st_r.cause    <= rcl_pkg::CAUSE_RESET;
      st_r.seg_lo   <= rcl_pkg::SEG_LO_RESET;
      st_r.seg_hi   <= rcl_pkg::SEG_HI_RESET;
      st_r.ctrl     <= rcl_pkg::CTRL_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Reset asserts in the request cycle itself; clock selection is not touched
  assign o_sys_rst     = rst_req || (st_r.hold_cnt != 4'h0);
  assign o_wake        = st_r.wake;
  assign o_cause       = st_r.cause;
  assign o_axi.awready = !st_r.aw_have && !st_r.bvalid;
  assign o_axi.wready  = !st_r.w_have && !st_r.bvalid;
  assign o_axi.bvalid  = st_r.bvalid;
  assign o_axi.bresp   = st_r.bresp;
  assign o_axi.arready = !st_r.rvalid;
  assign o_axi.rvalid  = st_r.rvalid;
  assign o_axi.rdata   = st_r.rdata;
  assign o_axi.rresp   = st_r.rresp;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  a_wdt_reset_line: assert property (wdt_rst |-> o_sys_rst ##1 st_r.hold_cnt == 4'h2)
    else $error("watchdog time-out did not assert reset");
  a_wdt_sleep_wake: assert property ((wdt_wake && !rst_req && st_r.hold_cnt == 4'h0)
                                     |-> !o_sys_rst ##1 o_wake)
    else $error("sleeping time-out must wake without reset");
  a_wdt_flag_set: assert property (wdt_rst |=> o_cause[4])
    else $error("watchdog flag not set");
  a_trap_conflict_flag: assert property (trap_conflict |-> o_sys_rst ##1 o_cause[15])
    else $error("trap conflict not logged");
  a_osc_trap_level: assert property ((i_trap_busy && i_trap_busy_lvl == 4'hf && i_hard_trap[1])
                                     |=> o_cause[15])
    else $error("oscillator trap under level 15 not a conflict");
  a_cfg_mismatch_flag: assert property (cfg_mismatch |-> o_sys_rst ##1 o_cause[9])
    else $error("pin-select mismatch not logged");
  a_illegal_opcode: assert property ((i_op_exec && i_op_word[23:16] == 8'h3f)
                                     |-> o_sys_rst ##1 o_cause[14])
    else $error("illegal opcode not reset");
  a_security_flag: assert property (sec_viol |-> o_sys_rst ##1 o_cause[14])
    else $error("security violation not logged");
  a_por_clears: assert property ((i_por && !rst_req) |=> o_cause == 16'h0003)
    else $error("power-on did not clear flags");
  a_bor_keeps_pin: assert property ((i_bor && !i_por && o_cause[7]) |=> o_cause[7])
    else $error("brown-out cleared pin reset flag");
  a_wdog_clear_flag: assert property ((i_wdog_clear && !wdt_rst) |=> !o_cause[4])
    else $error("watchdog clear left flag set");
  a_sw_write_cause: assert property ((wr_commit && wr_idx == 3'h0 && st_r.wstrb == 4'hf
                                      && !rst_req && !i_por && !i_bor && !i_wdog_clear
                                      && !i_psave_sleep && !i_psave_idle)
                                     |=> o_cause == ($past(st_r.wdata[15:0]) & 16'hc2df))
    else $error("software write to flags lost");
  a_sw_set_noreset: assert property ((wr_commit && !rst_req && st_r.hold_cnt == 4'h0)
                                     |-> !o_sys_rst)
    else $error("software flag write caused reset");
  a_flag_sticky: assert property ((o_cause[14] && !wr_commit && !i_por && !i_bor)
                                  |=> o_cause[14])
    else $error("illegal-condition flag dropped");

  c_wdt_reset: cover property (wdt_rst ##1 o_cause[4]);
  c_wdt_wake: cover property (wdt_wake ##1 o_wake);
  c_trap_conflict: cover property (trap_conflict);
  c_sw_clear: cover property (wr_commit && wr_idx == 3'h0 ##1 o_cause == 16'h0000);

endmodule

//--- core/rcl_wreg_track.sv
// Working-register initialisation tracker for the reset cause logger
`timescale 1ns/100ps
module rcl_wreg_track (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_clear,
  input  wire logic       i_wr,
  input  wire logic [3:0] i_wr_idx,
  input  wire logic       i_ptr_use,
  input  wire logic [3:0] i_ptr_idx,
  output logic            o_uninit
);

  rcl_pkg::rcl_wreg_state_t st_r;
  rcl_pkg::rcl_wreg_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (i_wr)
    begin
      st_nxt.valid[i_wr_idx] = 1'b1;
    end
    // Any reset wipes the array; the stack pointer stays usable
    if (i_clear)
    begin
      st_nxt.valid = 16'h0000;
    end
    st_nxt.valid[rcl_pkg::WREG_STACK] = 1'b1;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      st_r.valid <= 16'h8000;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_uninit = i_ptr_use && !st_r.valid[i_ptr_idx];

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  a_wreg_clear_all: assert property (i_clear |=> st_r.valid == 16'h8000)
    else $error("working registers not cleared by reset");
  a_wreg_pointer_trap: assert property (
    (i_clear ##1 (i_ptr_use && i_ptr_idx != rcl_pkg::WREG_STACK)) |-> o_uninit)
    else $error("uninitialised pointer use not flagged");

endmodule

//--- test/rcl_core_model.sv
// Core, trap and watchdog model: turns a command number into one cycle of events
`timescale 1ns/100ps
module rcl_core_model (
  input  wire logic [4:0]     i_cmd,
  output rcl_ev_pkg::rcl_ev_t o_ev
);
  always_comb
  begin
    o_ev = '0;
    // Shadow matches unless a command disturbs the live copy
    o_ev.pctl = 16'h00a5;
    o_ev.pshd = 16'h00a5;
    case (i_cmd)
      5'd1: o_ev.wd_tmo = 1'b1;
      5'd2: {o_ev.wd_tmo, o_ev.slp} = 2'h3;
      5'd23: {o_ev.wd_tmo, o_ev.idl} = 2'h3;
      5'd3: {o_ev.trap, o_ev.busy, o_ev.blvl} = {3'h1, 1'b1, 4'he};
      5'd4: {o_ev.trap, o_ev.busy, o_ev.blvl} = {3'h2, 1'b1, 4'hf};
      5'd5: {o_ev.trap, o_ev.busy, o_ev.blvl} = {3'h4, 1'b1, 4'hd};
      5'd6: o_ev.pctl = 16'h00a4;
      5'd7: {o_ev.pctl, o_ev.pupd} = {16'h00a4, 1'b1};
      5'd8: {o_ev.opx, o_ev.opw} = {1'b1, 24'h3f1234};
      5'd22: {o_ev.opx, o_ev.opw} = {1'b1, 24'h001234};
      5'd9: {o_ev.pu, o_ev.pidx} = {1'b1, 4'h3};
      5'd10: {o_ev.pu, o_ev.pidx} = {1'b1, 4'hf};
      5'd21: {o_ev.wwr, o_ev.widx} = {1'b1, 4'h3};
      5'd11: {o_ev.prog_flow, o_ev.tgt} = {1'b1, 24'h000180};
      5'd12: {o_ev.vec_flow, o_ev.tgt} = {1'b1, 24'h0001ff};
      5'd13: {o_ev.prog_flow, o_ev.tgt} = {1'b1, 24'h000200};
      5'd14: o_ev.pin = 1'b1;
      5'd15: o_ev.sw = 1'b1;
      5'd16: o_ev.clr = 1'b1;
      5'd17: o_ev.ps_slp = 1'b1;
      5'd18: o_ev.ps_idl = 1'b1;
      5'd19: o_ev.brownout = 1'b1;
      5'd20: o_ev.power_on = 1'b1;
      default: ;
    endcase
  end
endmodule

//--- test/rcl_ev_pkg.sv
// Event bundle carried from the core, trap and watchdog model to the logger
package rcl_ev_pkg;

  typedef struct packed {
    logic        power_on, brownout, pin, sw, wd_tmo, slp, idl, ps_slp, ps_idl, clr;
    logic [2:0]  trap;
    logic        busy;
    logic [3:0]  blvl;
    logic [15:0] pctl, pshd;
    logic        pupd, opx;
    logic [23:0] opw;
    logic        wwr;
    logic [3:0]  widx;
    logic        pu;
    logic [3:0]  pidx;
    logic        prog_flow, vec_flow;
    logic [23:0] tgt;
  } rcl_ev_t;

endpackage

//--- test/tb_top.sv
// Self-checking bench for the reset cause logger
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [4:0]  cmd;
    logic        rst;
    logic        wake;
    logic [15:0] cause;
  } rcl_row_t;

  // Each row starts from a cleared cause register
  localparam rcl_row_t ROWS [20] = '{
    '{5'd1, 1'b1, 1'b0, 16'h0010}, '{5'd2, 1'b0, 1'b1, 16'h0000},
    '{5'd23, 1'b0, 1'b1, 16'h0000}, '{5'd3, 1'b1, 1'b0, 16'h8000},
    '{5'd4, 1'b1, 1'b0, 16'h8000}, '{5'd5, 1'b0, 1'b0, 16'h0000},
    '{5'd6, 1'b1, 1'b0, 16'h0200}, '{5'd7, 1'b0, 1'b0, 16'h0000},
    '{5'd8, 1'b1, 1'b0, 16'h4000}, '{5'd22, 1'b0, 1'b0, 16'h0000},
    '{5'd9, 1'b1, 1'b0, 16'h4000}, '{5'd10, 1'b0, 1'b0, 16'h0000},
    '{5'd11, 1'b1, 1'b0, 16'h4000}, '{5'd12, 1'b1, 1'b0, 16'h4000},
    '{5'd13, 1'b0, 1'b0, 16'h0000}, '{5'd14, 1'b1, 1'b0, 16'h0080},
    '{5'd15, 1'b1, 1'b0, 16'h0040}, '{5'd16, 1'b0, 1'b0, 16'h0000},
    '{5'd17, 1'b0, 1'b0, 16'h0008}, '{5'd18, 1'b0, 1'b0, 16'h0004}
  };

  logic                  core_clk = 1'b0;
  logic                  rst_b = 1'b0;
  logic [4:0]            cmd = 5'd0;
  rcl_pkg::rcl_axi_req_t axi_q = '0;
  rcl_pkg::rcl_axi_rsp_t axi_s;
  rcl_ev_pkg::rcl_ev_t   ev;
  logic                  sys_rst;
  logic                  wake;
  logic [15:0]           cause;
  logic [31:0]           rd;
  logic [1:0]            rs;
  int                    failures = 0;
  int                    n_compared = 0;

  always #50 core_clk = ~core_clk;

  rcl_core_model model (.i_cmd(cmd), .o_ev(ev));

  rcl_top #(.PPS_W(16), .PA_W(24), .MM_EN(1'b1)) dut (
    .i_core_clk(core_clk), .i_rst_b(rst_b), .i_axi(axi_q), .o_axi(axi_s),
    .i_por(ev.power_on), .i_bor(ev.brownout), .i_master_clear_pin_rst(ev.pin),
    .i_sw_reset(ev.sw), .i_wdt_timeout(ev.wd_tmo), .i_cpu_sleep(ev.slp), .i_cpu_idle(ev.idl),
    .i_psave_sleep(ev.ps_slp), .i_psave_idle(ev.ps_idl), .i_wdog_clear(ev.clr),
    .i_hard_trap(ev.trap), .i_trap_busy(ev.busy), .i_trap_busy_lvl(ev.blvl),
    .i_pps_ctrl(ev.pctl), .i_pps_shadow(ev.pshd), .i_pps_update(ev.pupd),
    .i_op_exec(ev.opx), .i_op_word(ev.opw), .i_wreg_wr(ev.wwr), .i_wreg_wr_idx(ev.widx),
    .i_ptr_use(ev.pu), .i_ptr_idx(ev.pidx),
    .i_prog_flow(ev.prog_flow), .i_vec_flow(ev.vec_flow),
    .i_flow_target(ev.tgt), .o_sys_rst(sys_rst), .o_wake(wake), .o_cause(cause)
  );

  task results;
    $display("comparisons %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task tmo(input logic ok);
    if (ok !== 1'b1)
    begin
      failures++;
      $display("wrong value at %0t: bus answer never came", $time);
      results();
    end
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic aw_ok;
    logic w_ok;
    @(posedge core_clk);
    {axi_q.awvalid, axi_q.awaddr, axi_q.wvalid} <= {1'b1, a, 1'b1};
    {axi_q.wdata, axi_q.wstrb, axi_q.bready} <= {d, 4'hf, 1'b1};
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    // Readies stay low after acceptance, so a high ready means taken
    while (!(aw_ok && w_ok) && n < 50)
    begin
      @(posedge core_clk);
      n++;
      aw_ok = aw_ok || (axi_s.awready === 1'b1);
      w_ok = w_ok || (axi_s.wready === 1'b1);
      if (aw_ok)
        axi_q.awvalid <= 1'b0;
      if (w_ok)
        axi_q.wvalid <= 1'b0;
    end
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (axi_s.bvalid !== 1'b1 && n < 100);
    tmo(axi_s.bvalid);
    axi_q.bready <= 1'b0;
    r = axi_s.bresp;
  endtask

  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge core_clk);
    {axi_q.arvalid, axi_q.araddr, axi_q.rready} <= {1'b1, a, 1'b1};
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
      if (axi_s.arready === 1'b1)
        axi_q.arvalid <= 1'b0;
    end
    while (axi_s.rvalid !== 1'b1 && n < 50);
    tmo(axi_s.rvalid);
    axi_q.rready <= 1'b0;
    d = axi_s.rdata;
    r = axi_s.rresp;
  endtask

  // One event cycle; er of x skips the request and hold checks of the reset line where it is left open, not the release check
  task run_cmd(input logic [4:0] c, input logic er, input logic ew, input logic [15:0] ec);
    @(posedge core_clk);
    cmd <= c;
    #1;
    if (er !== 1'bx)
      chk(32'(sys_rst), 32'(er), "reset in request cycle");
    @(posedge core_clk);
    cmd <= 5'd0;
    #1;
    if (er !== 1'bx)
      chk(32'(sys_rst), 32'(er), "reset hold one");
    chk(32'(wake), 32'(ew), "wake pulse");
    chk(32'(cause), 32'(ec), "cause flags");
    @(posedge core_clk);
    #1;
    if (er !== 1'bx)
      chk(32'(sys_rst), 32'(er), "reset hold two");
    @(posedge core_clk);
    #1;
    chk(32'(sys_rst), 32'h0, "reset released");
  endtask

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(32'(cause), 32'h0003, "cause after reset");
    axi_rd(rcl_pkg::ADDR_CTRL, rd, rs);
    chk(rd, 32'h1, "control reset value");
    axi_rd(8'h10, rd, rs);
    chk(32'(rs), 32'(rcl_pkg::RESP_SLVERR), "unmapped response");
    chk(rd, 32'h0, "unmapped data");
    axi_wr(rcl_pkg::ADDR_SEG_LO, 32'h100, rs);
    axi_wr(rcl_pkg::ADDR_SEG_HI, 32'h1ff, rs);
    axi_wr(rcl_pkg::ADDR_CTRL, 32'h3, rs);
    axi_wr(rcl_pkg::ADDR_CAUSE, 32'hffffffff, rs);
    chk(32'(sys_rst), 32'h0, "software set resets");
    axi_rd(rcl_pkg::ADDR_CAUSE, rd, rs);
    chk(rd, 32'h0000c2df, "every flag set by software");
    foreach (ROWS[i])
    begin
      axi_wr(rcl_pkg::ADDR_CAUSE, 32'h0, rs);
      run_cmd(ROWS[i].cmd, ROWS[i].rst, ROWS[i].wake, ROWS[i].cause);
    end
    // Flags accumulate here; the idle flag of the last row is still set
    run_cmd(5'd1, 1'b1, 1'b0, 16'h0014);
    run_cmd(5'd16, 1'b0, 1'b0, 16'h0004);
    run_cmd(5'd1, 1'b1, 1'b0, 16'h0014);
    run_cmd(5'd18, 1'b0, 1'b0, 16'h0004);
    run_cmd(5'd14, 1'b1, 1'b0, 16'h0084);
    run_cmd(5'd19, 1'bx, 1'b0, 16'h0082);
    run_cmd(5'd20, 1'bx, 1'b0, 16'h0003);
    run_cmd(5'd21, 1'b0, 1'b0, 16'h0003);
    run_cmd(5'd9, 1'b0, 1'b0, 16'h0003);
    // Both checks switched off: the same events pass quietly
    axi_wr(rcl_pkg::ADDR_CTRL, 32'h0, rs);
    run_cmd(5'd6, 1'b0, 1'b0, 16'h0003);
    run_cmd(5'd11, 1'b0, 1'b0, 16'h0003);
    axi_wr(8'h10, 32'h0, rs);
    chk(32'(rs), 32'(rcl_pkg::RESP_SLVERR), "unmapped write response");
    // Dirty the flags so the mid-run reset has something to restore
    axi_wr(rcl_pkg::ADDR_CAUSE, 32'h0000c2df, rs);
    chk(32'(rs), 32'(rcl_pkg::RESP_OKAY), "write response");
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    #1;
    chk(32'(cause), 32'h0003, "cause after second reset");
    axi_rd(rcl_pkg::ADDR_CTRL, rd, rs);
    chk(rd, 32'h1, "control after second reset");
    results();
  end
endmodule
